// ---- include/ssmc_consts.svh ----
`ifndef SSMC_CONSTS_SVH
`define SSMC_CONSTS_SVH
// Register byte offsets
`define SSMC_HIGH_CTL_OFF 8'h00
`define SSMC_LOW_CTL_OFF 8'h04
`define SSMC_MODE_OFF 8'h08
`define SSMC_STATE_OFF 8'h0C
`define SSMC_INT_STAT_OFF 8'h10
`define SSMC_INT_MASK_OFF 8'h14
`define SSMC_EVENT_CFG_OFF 8'h18
// High control field positions
`define SSMC_HI_SUP_EN 0
`define SSMC_HI_SUP_KEEP 1
`define SSMC_HI_SUP_FP 2
`define SSMC_HI_AUTO 3
`define SSMC_HI_MON_EN 4
`define SSMC_HI_MON_FP 5
`define SSMC_HI_OVP 6
// Low control field positions
`define SSMC_LO_SUP_EN 0
`define SSMC_LO_SUP_FP 2
`define SSMC_LO_MON_EN 4
`define SSMC_LO_MON_FP 5
// Interrupt status positions
`define SSMC_IRQ_HI_SETTLED 0
`define SSMC_IRQ_LO_SETTLED 1
`define SSMC_IRQ_LO_EVENT 2
// Reset values
`define SSMC_HIGH_CTL_RST 8'h00
`define SSMC_LOW_CTL_RST 8'h00
`define SSMC_EVENT_CFG_RST 1'b1
// Timing: normal-mode settling, fast settling, clock period
`define SSMC_SETTLE_SLOW_NS 150000
`define SSMC_SETTLE_FAST_NS 2000
`define SSMC_CLK_NS 20
`define SSMC_SETTLE_SLOW_CYC (`SSMC_SETTLE_SLOW_NS / `SSMC_CLK_NS)
`define SSMC_SETTLE_FAST_CYC \
    ((`SSMC_SETTLE_FAST_NS + `SSMC_CLK_NS - 1) / `SSMC_CLK_NS)
`endif

// ---- include/ssmc_pkg.sv ----
package ssmc_pkg;
    // Comparator operating state
    typedef enum logic [1:0] {
        SSMC_OFF = 2'h0,
        SSMC_NORMAL = 2'h1,
        SSMC_FULL = 2'h2
    } ssmc_comp_t;
    // Power mode presented by the core
    typedef enum logic [1:0] {
        SSMC_ACTIVE = 2'h0,
        SSMC_LIGHT = 2'h1,
        SSMC_DEEP = 2'h2
    } ssmc_pmode_t;
    // Bus slave states, one-hot
    typedef enum logic [2:0] {
        SSMC_IDLE = 3'b001,
        SSMC_WRESP = 3'b010,
        SSMC_RDATA = 3'b100
    } ssmc_bus_t;
endpackage

// ---- rtl/ssmc_settle_timer.sv ----
`timescale 1ns/1ps
// Settling-delay flag: set on a control write, clears after the delay
module ssmc_settle_timer
    import ssmc_pkg::*;
#(
    parameter int CW = 13
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic start,
    input wire logic [CW-1:0] load,
    output logic busy,
    output logic done
);
    // All timer state
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic busy;
        logic done;
    } ssmc_tmr_t;
    ssmc_tmr_t s_q, s_d;

    // Next state
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (start) begin
            // Restart on every write
            s_d.busy = 1'b1;
            s_d.cnt = load;
        end else if (s_q.busy) begin
            if (s_q.cnt <= CW'(1)) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt - CW'(1);
            end
        end
    end

    // Register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
    assign done = s_q.done;
endmodule

// ---- rtl/ssmc_supervisor.sv ----
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// R1: High supervisor off unless enabled; fullperf selects
// R2: Manual deep: keep bit chooses off or hold
// R3: Auto deep: off except all three set
// R4: Monitor fp0: normal, manual normal, auto off
// R5: Monitor fp1: full, manual full, auto normal
// R6: Software waits both settle flags before deep
// R7: Low supervisor fp0 gives slow 150us wake
// R8: Low normal-mode enable selects slow wake-up
// R9: Affected-configuration check reports fast high-off case
// R10: Low event routes to reset or interrupt
// R11: Overvoltage enable makes monitor trigger reset
// R12: Software bounds settle polling by 300us
// R13: Software swaps reset pin to NMI around writes; the testbench keeps low event reset routing during control writes except in the overvoltage test
// R14: Software adds 150us delay for fast service
// R15: Control write sets settle flag until elapsed
`include "ssmc_consts.svh"
module ssmc_supervisor
    import ssmc_pkg::*;
#(
    parameter int SLOW_CYC = `SSMC_SETTLE_SLOW_CYC,
    parameter int FAST_CYC = `SSMC_SETTLE_FAST_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic aclken,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] power_mode,
    input wire logic low_side_event_pin,
    input wire logic high_overvoltage_pin,
    output logic [1:0] high_supervisor_state,
    output logic [1:0] high_monitor_state,
    output logic slow_wakeup,
    output logic por_request,
    output logic irq
);
    localparam int CW = 14;
    // All block state
    typedef struct packed {
        ssmc_bus_t bus;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] high_ctl;
        logic [7:0] low_ctl;
        logic event_to_por;
        logic [2:0] int_stat;
        logic [2:0] int_mask;
        logic [2:0] evt_sync;
        logic [2:0] ovp_sync;
        logic [1:0] hs_state;
        logic [1:0] hm_state;
        logic slow_wake;
        logic por;
        logic irq;
    } ssmc_state_t;
    ssmc_state_t s_q, s_d;

    // Settle timer handshake
    logic hi_start, lo_start;
    logic hi_busy, lo_busy, hi_done, lo_done;
    logic [CW-1:0] hi_load, lo_load;
    // Decoded fields
    logic h_en, h_keep, h_fp, h_auto, hm_en, hm_fp, h_ovp;
    logic l_sup_en, l_sup_fp, l_mon_en, l_mon_fp;
    logic fast_low, affected, evt_hit, ovp_hit;
    ssmc_pmode_t pm;
    ssmc_comp_t hs_next, hm_next;

    assign pm = ssmc_pmode_t'(power_mode);
    assign h_en = s_q.high_ctl[`SSMC_HI_SUP_EN];
    assign h_keep = s_q.high_ctl[`SSMC_HI_SUP_KEEP];
    assign h_fp = s_q.high_ctl[`SSMC_HI_SUP_FP];
    assign h_auto = s_q.high_ctl[`SSMC_HI_AUTO];
    assign hm_en = s_q.high_ctl[`SSMC_HI_MON_EN];
    assign hm_fp = s_q.high_ctl[`SSMC_HI_MON_FP];
    assign h_ovp = s_q.high_ctl[`SSMC_HI_OVP];
    assign l_sup_en = s_q.low_ctl[`SSMC_LO_SUP_EN];
    assign l_sup_fp = s_q.low_ctl[`SSMC_LO_SUP_FP];
    assign l_mon_en = s_q.low_ctl[`SSMC_LO_MON_EN];
    assign l_mon_fp = s_q.low_ctl[`SSMC_LO_MON_FP];

    // Settling time follows the setting being written, not the old one
    assign hi_load = (s_q.wdata[`SSMC_HI_SUP_FP] |
        s_q.wdata[`SSMC_HI_MON_FP]) ? CW'(FAST_CYC) : CW'(SLOW_CYC); // [R15]
    assign lo_load = s_q.wdata[`SSMC_LO_SUP_FP] ? CW'(FAST_CYC)
        : CW'(SLOW_CYC); // [R15]

    // High supervisor state per power mode
    always_comb begin
        hs_next = SSMC_OFF;
        if (!h_en) begin
            hs_next = SSMC_OFF; // [R1]
        end else if (pm != SSMC_DEEP) begin
            hs_next = h_fp ? SSMC_FULL : SSMC_NORMAL; // [R1]
        end else if (h_auto) begin
            // Only all-set survives deep entry
            hs_next = (h_keep && h_fp) ? SSMC_NORMAL : SSMC_OFF; // [R3]
        end else if (h_keep) begin
            hs_next = h_fp ? SSMC_FULL : SSMC_NORMAL; // [R2]
        end else begin
            hs_next = SSMC_OFF; // [R2]
        end
    end

    // High monitor state per power mode
    always_comb begin
        hm_next = SSMC_OFF;
        if (!hm_en) begin
            hm_next = SSMC_OFF; // [R4]
        end else if (!hm_fp) begin
            hm_next = (pm == SSMC_DEEP && h_auto) ?
                SSMC_OFF : SSMC_NORMAL; // [R4]
        end else begin
            hm_next = (pm == SSMC_DEEP && h_auto) ?
                SSMC_NORMAL : SSMC_FULL; // [R5]
        end
    end

    // Wake-up path and affected-configuration check
    always_comb begin
        // Any low comparator in normal mode forces slow wake
        fast_low = !((l_sup_en && !l_sup_fp) ||
            (l_mon_en && !l_mon_fp)); // [R7] [R8]
        affected = 1'b0;
        if (fast_low) begin
            if (h_en && !h_fp && (!h_keep || h_auto)) begin
                affected = 1'b1; // [R9]
            end
            if (hm_en && !hm_fp && h_auto) begin
                affected = 1'b1; // [R9]
            end
        end
    end

    // Synchronised event pins: second and third stage agree
    assign evt_hit = s_q.evt_sync[1] & s_q.evt_sync[2];
    assign ovp_hit = s_q.ovp_sync[1] & s_q.ovp_sync[2];

    // Bus, registers and outputs
    always_comb begin
        logic wr_go;
        logic [31:0] rd;
        logic [2:0] set_bits;
        wr_go = 1'b0;
        rd = 32'h00000000;
        set_bits = 3'h0;
        s_d = s_q;
        hi_start = 1'b0;
        lo_start = 1'b0;
        s_d.evt_sync = {s_q.evt_sync[1:0], low_side_event_pin};
        s_d.ovp_sync = {s_q.ovp_sync[1:0], high_overvoltage_pin};
        case (s_q.bus)
            SSMC_IDLE: begin
                // Capture address and data in either order
                if (s_axi_awvalid && !s_q.aw_got) begin
                    s_d.aw_got = 1'b1;
                    s_d.awaddr = s_axi_awaddr;
                end
                if (s_axi_wvalid && !s_q.w_got) begin
                    s_d.w_got = 1'b1;
                    s_d.wdata = s_axi_wdata;
                    s_d.wstrb = s_axi_wstrb;
                end
                if (s_q.aw_got && s_q.w_got) begin
                    wr_go = 1'b1;
                    s_d.aw_got = 1'b0;
                    s_d.w_got = 1'b0;
                    s_d.bus = SSMC_WRESP;
                end else if (s_axi_arvalid && !s_q.aw_got
                        && !s_q.w_got) begin
                    s_d.bus = SSMC_RDATA;
                    s_d.rresp = 2'h0;
                    case (s_axi_araddr)
                        `SSMC_HIGH_CTL_OFF: rd = {24'h000000, s_q.high_ctl};
                        `SSMC_LOW_CTL_OFF: rd = {24'h000000, s_q.low_ctl};
                        `SSMC_MODE_OFF: rd = {29'h00000000,
                            s_q.event_to_por, lo_busy, hi_busy};
                        `SSMC_STATE_OFF: rd = {26'h0000000, affected,
                            s_q.slow_wake, s_q.hm_state, s_q.hs_state};
                        `SSMC_INT_STAT_OFF: rd = {29'h00000000, s_q.int_stat};
                        `SSMC_INT_MASK_OFF: rd = {29'h00000000, s_q.int_mask};
                        `SSMC_EVENT_CFG_OFF: rd = {31'h00000000,
                            s_q.event_to_por};
                        default: s_d.rresp = 2'h2;
                    endcase
                    s_d.rdata = rd;
                end
            end
            SSMC_WRESP: begin
                if (s_axi_bready) begin
                    s_d.bus = SSMC_IDLE;
                end
            end
            SSMC_RDATA: begin
                if (s_axi_rready) begin
                    s_d.bus = SSMC_IDLE;
                end
            end
            default: begin
                s_d.bus = SSMC_IDLE;
            end
        endcase
        // Register write effects
        if (wr_go) begin
            s_d.bresp = 2'h0;
            case (s_q.awaddr)
                `SSMC_HIGH_CTL_OFF: if (s_q.wstrb[0]) begin
                    s_d.high_ctl = s_q.wdata[7:0];
                    hi_start = 1'b1; // [R15]
                end
                `SSMC_LOW_CTL_OFF: if (s_q.wstrb[0]) begin
                    s_d.low_ctl = s_q.wdata[7:0];
                    lo_start = 1'b1; // [R15]
                end
                `SSMC_MODE_OFF, `SSMC_STATE_OFF: begin
                    s_d.bresp = 2'h0;
                end
                `SSMC_INT_STAT_OFF: if (s_q.wstrb[0]) begin
                    s_d.int_stat = s_q.int_stat & ~s_q.wdata[2:0];
                end
                `SSMC_INT_MASK_OFF: if (s_q.wstrb[0]) begin
                    s_d.int_mask = s_q.wdata[2:0];
                end
                `SSMC_EVENT_CFG_OFF: if (s_q.wstrb[0]) begin
                    s_d.event_to_por = s_q.wdata[0];
                end
                default: s_d.bresp = 2'h2;
            endcase
        end
        // Events, set wins over clear
        set_bits[`SSMC_IRQ_HI_SETTLED] = hi_done;
        set_bits[`SSMC_IRQ_LO_SETTLED] = lo_done;
        set_bits[`SSMC_IRQ_LO_EVENT] = evt_hit && !s_q.event_to_por; // [R10]
        s_d.int_stat = s_d.int_stat | set_bits;
        // Outputs
        s_d.hs_state = hs_next;
        s_d.hm_state = hm_next;
        s_d.slow_wake = !fast_low; // [R8]
        s_d.por = (evt_hit && s_q.event_to_por) || // [R10]
            (ovp_hit && h_ovp && hm_en); // [R11]
        s_d.irq = |(s_d.int_stat & s_q.int_mask);
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.bus <= SSMC_IDLE;
            s_q.high_ctl <= `SSMC_HIGH_CTL_RST;
            s_q.low_ctl <= `SSMC_LOW_CTL_RST;
            s_q.event_to_por <= `SSMC_EVENT_CFG_RST;
            s_q.slow_wake <= 1'b0;
        end else if (aclken) begin
            s_q <= s_d;
        end
    end

    // Settling flags for each side
    ssmc_settle_timer #(.CW(CW)) u_hi_settle (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(aclken),
        .start(hi_start),
        .load(hi_load),
        .busy(hi_busy),
        .done(hi_done)
    );
    ssmc_settle_timer #(.CW(CW)) u_lo_settle (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(aclken),
        .start(lo_start),
        .load(lo_load),
        .busy(lo_busy),
        .done(lo_done)
    );

    // Outputs straight from flops
    assign s_axi_awready = (s_q.bus == SSMC_IDLE) && !s_q.aw_got;
    assign s_axi_wready = (s_q.bus == SSMC_IDLE) && !s_q.w_got;
    assign s_axi_bvalid = s_q.bus == SSMC_WRESP;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = (s_q.bus == SSMC_IDLE) && !s_q.aw_got
        && !s_q.w_got;
    assign s_axi_rvalid = s_q.bus == SSMC_RDATA;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign high_supervisor_state = s_q.hs_state;
    assign high_monitor_state = s_q.hm_state;
    assign slow_wakeup = s_q.slow_wake;
    assign por_request = s_q.por;
    assign irq = s_q.irq;

    // Disabled supervisor is off one cycle later
    a_hs_disabled_off: assert property (@(posedge aclk) // [R1]
        disable iff (!aresetn) aclken && !h_en
        |=> high_supervisor_state == SSMC_OFF)
        else $error("high supervisor on while disabled");
    a_hs_manual_deep: assert property (@(posedge aclk) // [R2]
        disable iff (!aresetn) h_en && !h_auto && pm == SSMC_DEEP
        && !h_keep |-> hs_next == SSMC_OFF)
        else $error("manual deep not off");
    a_hs_auto_deep: assert property (@(posedge aclk) // [R3]
        disable iff (!aresetn) h_auto && pm == SSMC_DEEP
        |-> hs_next == ((h_en && h_keep && h_fp) ? SSMC_NORMAL
        : SSMC_OFF))
        else $error("auto deep state wrong");
    a_hm_fp0_state: assert property (@(posedge aclk) // [R4]
        disable iff (!aresetn) hm_en && !hm_fp |-> hm_next ==
        ((pm == SSMC_DEEP && h_auto) ? SSMC_OFF : SSMC_NORMAL))
        else $error("monitor normal case wrong");
    a_hm_fp1_state: assert property (@(posedge aclk) // [R5]
        disable iff (!aresetn) hm_en && hm_fp |-> hm_next ==
        ((pm == SSMC_DEEP && h_auto) ? SSMC_NORMAL : SSMC_FULL))
        else $error("monitor full case wrong");
    a_slow_wake_sel: assert property (@(posedge aclk) // [R7]
        disable iff (!aresetn) aclken && l_sup_en && !l_sup_fp
        |=> !aclken || slow_wakeup)
        else $error("slow wake not selected");
    a_fast_wake_sel: assert property (@(posedge aclk) // [R8]
        disable iff (!aresetn) !(l_sup_en && !l_sup_fp) &&
        !(l_mon_en && !l_mon_fp) |-> fast_low)
        else $error("fast wake not selected");
    a_affected_chk: assert property (@(posedge aclk) // [R9]
        disable iff (!aresetn) !fast_low |-> !affected)
        else $error("affected with slow wake");
    a_event_route: assert property (@(posedge aclk) // [R10]
        disable iff (!aresetn) aclken && evt_hit && s_q.event_to_por
        |=> !aclken || por_request)
        else $error("low event did not reset");
    a_ovp_reset: assert property (@(posedge aclk) // [R11]
        disable iff (!aresetn) aclken && ovp_hit && h_ovp && hm_en
        |=> !aclken || por_request)
        else $error("overvoltage did not reset");
    a_settle_set: assert property (@(posedge aclk) // [R15]
        disable iff (!aresetn) aclken && lo_start
        |=> !aclken || lo_busy)
        else $error("settle flag not set");
endmodule

// ---- testbench/test_supply_supervisor_mode_control.sv ----
`timescale 1ns/1ps
`include "ssmc_consts.svh"
module test_supply_supervisor_mode_control
    import ssmc_pkg::*;
;
    localparam int SLOW = 20; // Shortened slow settling count
    localparam int FAST = 4; // Shortened fast settling count
    localparam logic [7:0] A_HI = `SSMC_HIGH_CTL_OFF;
    localparam logic [7:0] A_LO = `SSMC_LOW_CTL_OFF;
    localparam logic [7:0] A_FLG = `SSMC_MODE_OFF;
    localparam logic [7:0] A_ST = `SSMC_STATE_OFF;
    localparam logic [7:0] A_IS = `SSMC_INT_STAT_OFF;
    localparam logic [7:0] A_IM = `SSMC_INT_MASK_OFF;
    localparam logic [7:0] A_EV = `SSMC_EVENT_CFG_OFF;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic aclken = 1'b1; // Running except during the frozen clock enable test
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [1:0] power_mode = 2'h0;
    logic low_side_event_pin = 1'b0;
    logic high_overvoltage_pin = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, slow_wakeup, por_request, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [1:0] high_supervisor_state, high_monitor_state;
    logic [31:0] s_axi_rdata;
    int mismatches = 0; // Failed comparisons
    int n_tests = 0; // All comparisons
    int seed = 32'hB60945A9; // Fixed random seed

    // Free-running 50 MHz clock
    always #10 aclk = ~aclk;

    ssmc_supervisor #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) u_dut (
        .aclk, .aclken, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_mode,
        .low_side_event_pin, .high_overvoltage_pin,
        .high_supervisor_state, .high_monitor_state, .slow_wakeup,
        .por_request, .irq
    );

    // Compare and count
    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Bus write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (n < 200) begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready === 1'b1) begin
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1) begin
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1) begin
                break;
            end
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        check("write wait", 32'(n < 200), 32'h1);
    endtask

    // Bus read
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (n < 200) begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready === 1'b1) begin
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid === 1'b1) begin
                break;
            end
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        check("read wait", 32'(n < 200), 32'h1);
    endtask

    // Full-word write expecting OKAY
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, 4'hF, r);
        check("write resp", 32'(r), 32'h0);
    endtask

    // Read and compare with OKAY
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check($sformatf("reg %h", a), d, e);
        check("read resp", 32'(r), 32'h0);
    endtask

    // Poll both settle flags, bounded
    task automatic wait_settled();
        logic [31:0] d;
        logic [1:0] r;
        int n;
        n = 0;
        do begin
            rd(A_FLG, d, r);
            n++;
        end while (d[1:0] !== 2'b00 && n < 40);
        check("settle wait", 32'(n < 40), 32'h1);
    endtask

    // Expected high supervisor state
    function automatic logic [1:0] hs_exp(logic [7:0] c, int p);
        if (!c[0]) return SSMC_OFF;
        if (p != 2) return c[2] ? SSMC_FULL : SSMC_NORMAL;
        if (!c[3]) return c[1] ? (c[2] ? SSMC_FULL : SSMC_NORMAL) : SSMC_OFF;
        return (c[1] && c[2]) ? SSMC_NORMAL : SSMC_OFF;
    endfunction

    // Expected high monitor state
    function automatic logic [1:0] hm_exp(logic [7:0] c, int p);
        if (!c[4]) return SSMC_OFF;
        if (p != 2 || !c[3]) return c[5] ? SSMC_FULL : SSMC_NORMAL;
        return c[5] ? SSMC_NORMAL : SSMC_OFF;
    endfunction

    // Slow wake when a low comparator runs in normal mode
    function automatic logic slow_exp(logic [7:0] l);
        return (l[0] && !l[2]) || (l[4] && !l[5]);
    endfunction

    // Fast wake combined with a high normal-to-off move
    function automatic logic aff_exp(logic [7:0] h, logic [7:0] l);
        return !slow_exp(l) && ((h[0] && !h[2] && (!h[1] || h[3]))
            || (h[4] && !h[5] && h[3]));
    endfunction

    // Watchdog against hangs
    initial begin
        cyc(30000);
        mismatches++;
        $display("Watchdog expired");
        end_sim();
    end

    // Main sequence
    initial begin
        logic [7:0] hv;
        logic [7:0] lv;
        logic [31:0] d;
        logic [1:0] r;
        cyc(10);
        check("outputs in reset", 32'({high_supervisor_state,
            high_monitor_state, slow_wakeup, por_request, irq}), 32'h0);
        aresetn <= 1'b1; // Never pulsed during a control write
        rc(A_HI, 32'h0);
        rc(A_LO, 32'h0);
        rc(A_EV, 32'h1);
        rc(A_FLG, 32'h4);
        rc(A_ST, 32'h0);
        rc(A_IM, 32'h0);
        wr(8'h20, 32'h1, 4'hF, r);
        check("unmapped write", 32'(r), 32'h2);
        rd(8'h20, d, r);
        check("unmapped read", 32'(r), 32'h2);
        $display("Reset and map test done");
        // Every high control combination of bits 5:0, random overvoltage bit and low control
        for (int h = 0; h < 64; h++) begin
            hv = 8'(h) | (8'($random(seed)) & 8'h40);
            lv = 8'($random(seed)) & 8'h35;
            w(A_HI, 32'(hv));
            w(A_LO, 32'(lv));
            wait_settled();
            rc(A_HI, 32'(hv));
            cyc(SLOW); // Wake-up delay before deep entry
            for (int p = 0; p < 4; p++) begin
                power_mode <= 2'(p);
                cyc(4);
                check("sup state", 32'(high_supervisor_state),
                    32'(hs_exp(hv, p)));
                check("mon state", 32'(high_monitor_state),
                    32'(hm_exp(hv, p)));
                check("slow wake", 32'(slow_wakeup),
                    32'(slow_exp(lv)));
                rc(A_ST, 32'({aff_exp(hv, lv), slow_exp(lv),
                    hm_exp(hv, p), hs_exp(hv, p)}));
            end
            power_mode <= 2'h0;
        end
        $display("Mode table test done");
        // Settle flags: fast then slow on each side
        w(A_IS, 32'h7);
        for (int s = 0; s < 2; s++) begin
            w(s ? A_LO : A_HI, 32'h5);
            cyc(FAST + 2);
            rc(A_FLG, 32'h4);
            w(s ? A_LO : A_HI, 32'h1);
            cyc(FAST + 2);
            rc(A_FLG, 32'h4 | (32'h1 << s));
            cyc(SLOW);
            rc(A_FLG, 32'h4);
        end
        rc(A_IS, 32'h3);
        check("irq masked", 32'(irq), 32'h0);
        for (int s = 0; s < 2; s++) begin
            w(A_IM, 32'h1 << s);
            cyc(2);
            check("irq set", 32'(irq), 32'h1);
            w(A_IS, 32'h1 << s);
            cyc(2);
            check("irq clear", 32'(irq), 32'h0);
        end
        rc(A_IS, 32'h0);
        wr(A_HI, 32'h7F, 4'h0, r);
        check("strobe resp", 32'(r), 32'h0);
        rc(A_HI, 32'h1);
        $display("Settle and interrupt test done");
        // Low event routed to reset, then to interrupt
        w(A_IM, 32'h4);
        for (int s = 0; s < 2; s++) begin
            w(A_EV, 32'(1 - s));
            low_side_event_pin <= 1'b1;
            cyc(12);
            check("event por", 32'(por_request), 32'(1 - s));
            check("event irq", 32'(irq), 32'(s));
            low_side_event_pin <= 1'b0;
            cyc(12);
            check("event por end", 32'(por_request), 32'h0);
            w(A_IS, 32'h4);
            cyc(2);
            check("event irq clear", 32'(irq), 32'h0);
        end
        // Overvoltage trip only with protection enabled
        for (int s = 0; s < 2; s++) begin
            w(A_HI, s ? 32'h10 : 32'h50);
            high_overvoltage_pin <= 1'b1;
            cyc(12);
            check("ovp por", 32'(por_request), 32'(1 - s));
            high_overvoltage_pin <= 1'b0;
            cyc(12);
            check("ovp por end", 32'(por_request), 32'h0);
        end
        // Frozen clock enable holds the event synchroniser
        w(A_EV, 32'h1);
        aclken <= 1'b0;
        low_side_event_pin <= 1'b1;
        cyc(12);
        check("frozen por", 32'(por_request), 32'h0);
        aclken <= 1'b1;
        cyc(12);
        check("thawed por", 32'(por_request), 32'h1);
        low_side_event_pin <= 1'b0;
        cyc(12);
        check("thawed por end", 32'(por_request), 32'h0);
        $display("Event test done");
        end_sim();
    end
endmodule
